// ==== fbs_master_model.sv ====
// Purpose: Behavioural fieldbus master driving the slave's frame ports
// Assumes: Caller orders parameter frame before config frame
// Notes:   gap slows the master between frames
`default_nettype none
module fbs_master_model
  import fbs_pkg::*;
(
  // Clock and answers
  input  wire logic        clk_sys,
  input  wire logic        txValid,
  input  wire logic [15:0] txWord,
  // Frames
  output logic             prmValid,
  output logic      [6:0]  prmStation,
  output logic             prmWdogEn,
  output logic      [15:0] prmWdogFactor,
  output logic      [7:0]  prmMinTsdr,
  output logic      [7:0]  prmGroups,
  output logic             prmSwap,
  output logic             prmLayout,
  output logic             cfgValid,
  output logic      [5:0]  cfgModCount,
  output logic      [6:0]  cfgMaxPattern,
  output logic             frameRx,
  output logic             linkStop,
  output logic             gcValid,
  output fbs_gc_t          gcCmd,
  output logic      [7:0]  gcGroups,
  output logic             rxWordValid,
  output logic      [7:0]  rxWordIdx,
  output logic      [15:0] rxWord,
  output logic             txReq,
  output logic      [7:0]  txWordIdx
);
  int gap = 0;
  initial
  begin
    {prmValid, prmStation, prmWdogEn, prmWdogFactor, prmMinTsdr, prmGroups} = '0;
    {prmSwap, prmLayout, cfgValid, cfgModCount, cfgMaxPattern, frameRx, linkStop} = '0;
    {gcValid, gcGroups, rxWordValid, rxWordIdx, rxWord, txReq, txWordIdx} = '0;
    gcCmd = FBS_GC_SYNC;
  end
  // Every frame also kicks the slave's watchdog
  task automatic go();
    repeat (gap + 1) @(posedge clk_sys);
    frameRx <= 1'b1;
  endtask
  task automatic fin();
    @(posedge clk_sys);
    {prmValid, cfgValid, gcValid, rxWordValid, txReq, frameRx, linkStop} <= '0;
    // Released rxWord and gcGroups lines must not keep their value
    rxWord <= ~rxWord;
    gcGroups <= ~gcGroups;
  endtask
  task automatic send_prm(input logic [6:0] st, input logic en, input logic [15:0] f,
                          input logic [7:0] t, input logic [7:0] g, input logic [1:0] sl);
    go();
    prmValid <= 1'b1;
    {prmStation, prmWdogEn, prmWdogFactor} <= {st, en, f};
    {prmMinTsdr, prmGroups, prmSwap, prmLayout} <= {t, g, sl};
    fin();
  endtask
  task automatic send_cfg(input logic [5:0] n, input logic [6:0] p);
    go();
    {cfgValid, cfgModCount, cfgMaxPattern} <= {1'b1, n, p};
    fin();
  endtask
  task automatic send_gc(input fbs_gc_t c, input logic [7:0] g);
    go();
    {gcValid, gcGroups} <= {1'b1, g};
    gcCmd <= c;
    fin();
  endtask
  task automatic send_rx(input logic [7:0] i, input logic [15:0] d);
    go();
    {rxWordValid, rxWordIdx, rxWord} <= {1'b1, i, d};
    fin();
  endtask
  task automatic fetch(input logic [7:0] i, output logic [15:0] d);
    go();
    {txReq, txWordIdx} <= {1'b1, i};
    fin();
    for (int n = 0; n < 600 && txValid !== 1'b1; n++)
      @(posedge clk_sys) #1;
    d = txWord;
  endtask
  task automatic drop_link();
    go();
    linkStop <= 1'b1;
    fin();
  endtask
endmodule
`default_nettype wire

// ==== fbs_pkg.sv ====
// Purpose: Shared constants for the fieldbus slave sync/freeze/swap block
// Assumes: 20 MHz system clock, 16-bit local word bus
// Notes:   Word addresses on the local port, not byte addresses
`default_nettype none
package fbs_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 50;
  localparam int WDOG_UNIT_NS   = 10_000_000;
  localparam int WDOG_TICK_CYC  = (WDOG_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TSDR_BIT_CYC   = 1;
  // ----------------------------------------
  // Parameter ranges
  // ----------------------------------------
  localparam logic [6:0]  ADDR_MAX     = 7'h7d;
  localparam logic [15:0] WDOG_MIN     = 16'h0002;
  localparam logic [15:0] WDOG_MAX     = 16'hfe01;
  localparam logic [7:0]  TSDR_MIN     = 8'h01;
  localparam logic [5:0]  MOD_MIN      = 6'h01;
  localparam logic [5:0]  MOD_MAX      = 6'h28;
  localparam logic [6:0]  PAT_COUNT    = 7'h60;
  localparam int          NUM_GROUPS   = 8;
  // ----------------------------------------
  // User parameter encodings
  // ----------------------------------------
  localparam logic SWAP_OFF          = 1'b0;
  localparam logic SWAP_ON           = 1'b1;
  localparam logic CONTIGUOUS_LAYOUT = 1'b0;
  localparam logic SPLIT_LAYOUT      = 1'b1;
  // ----------------------------------------
  // Local word map
  // ----------------------------------------
  localparam int          AREA_WORDS  = 192;
  localparam logic [11:0] OUT_BASE    = 12'h000;
  localparam logic [11:0] OUT_LAST    = 12'h0bf;
  localparam logic [11:0] IN_BASE     = 12'h100;
  localparam logic [11:0] IN_LAST     = 12'h1bf;
  localparam logic [11:0] REG_STATUS  = 12'h200;
  localparam logic [11:0] REG_PRM0    = 12'h201;
  localparam logic [11:0] REG_PRM1    = 12'h202;
  localparam logic [11:0] REG_CTRL    = 12'h203;
  // Status bit positions
  localparam int ST_LINK   = 0;
  localparam int ST_ERR    = 1;
  localparam int ST_SYNC   = 2;
  localparam int ST_FREEZE = 3;
  localparam int ST_SWAP   = 4;
  localparam int ST_LAYOUT = 5;
  localparam int ST_PRMBAD = 6;
  // Control bit positions
  localparam int CT_ERRCLR = 0;
  // Global control command encodings
  typedef enum logic [1:0] {
    FBS_GC_SYNC     = 2'h0,
    FBS_GC_UNSYNC   = 2'h1,
    FBS_GC_FREEZE   = 2'h2,
    FBS_GC_UNFREEZE = 2'h3
  } fbs_gc_t;
endpackage
`default_nettype wire

// ==== fbs_resp_delay.sv ====
// Purpose: Holds off a response for at least the minimum response delay
// Assumes: start is a one-cycle pulse
// Notes:   A start while busy restarts the wait
`default_nettype none
module fbs_resp_delay
  import fbs_pkg::*;
#(
  parameter int BIT_CYCLES = TSDR_BIT_CYC
)(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Request
  input  wire logic       start,
  input  wire logic [7:0] bits,
  // Result
  output logic            done
);
  logic [17:0] cnt_ff;
  logic        busy_ff;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      cnt_ff  <= 18'h0;
      busy_ff <= 1'b0;
      done    <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cnt_ff  <= 18'(bits * BIT_CYCLES);
        busy_ff <= 1'b1;
      end
      else if (busy_ff)
      begin
        if (cnt_ff <= 18'h1)
        begin
          busy_ff <= 1'b0;
          done    <= 1'b1;
        end
        else
          cnt_ff <= cnt_ff - 18'h1;
      end
    end
endmodule
`default_nettype wire

// ==== fbs_slave.sv ====
// Purpose: Fieldbus slave global control, word swap and slave parameters
// Assumes: Link-side frame decoding is done outside; events arrive as pulses
// Notes:   Output receive area at 000h-0BFh, input send area at 100h-1BFh
//
// How it works
// - SYNC for our group enters output sync
// - In sync, outputs change only on SYNC
// - UNSYNC leaves output sync, normal updating
// - FREEZE samples inputs, holds until next FREEZE
// - UNFREEZE leaves input sync, live inputs
// - Eight groups, one through eight
// - Any combination of group membership allowed
// - Swap exchanges bytes of every word
// - Swapped input words sent to master
// - Swapped received words written to output area
// - Swap flag: 0 none default, 1 swap
// - Layout flag: 0 contiguous default, 1 split
// - Station address limited to 0..125
// - Watchdog error after factor times 10 ms
// - No watchdog configured, never time out
// - Wait minimum response delay before responding
// - One to forty modules, 96 patterns
// - Input words come from 100h-1BFh
// - Link-active flag while exchange is possible
`default_nettype none
module fbs_slave
  import fbs_pkg::*;
#(
  parameter int WDOG_TICK = WDOG_TICK_CYC,
  parameter int BIT_CYC   = TSDR_BIT_CYC
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Local register port
  input  wire logic [11:0] regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // Parameter frame from master
  input  wire logic        prmValid,
  input  wire logic [6:0]  prmStation,
  input  wire logic        prmWdogEn,
  input  wire logic [15:0] prmWdogFactor,
  input  wire logic [7:0]  prmMinTsdr,
  input  wire logic [7:0]  prmGroups,
  input  wire logic        prmSwap,
  input  wire logic        prmLayout,
  // Configuration frame from master
  input  wire logic        cfgValid,
  input  wire logic [5:0]  cfgModCount,
  input  wire logic [6:0]  cfgMaxPattern,
  // Link events
  input  wire logic        frameRx,
  input  wire logic        linkStop,
  // Global control
  input  wire logic        gcValid,
  input  wire fbs_gc_t     gcCmd,
  input  wire logic [7:0]  gcGroups,
  // Output words from master
  input  wire logic        rxWordValid,
  input  wire logic [7:0]  rxWordIdx,
  input  wire logic [15:0] rxWord,
  // Input words to master
  input  wire logic        txReq,
  input  wire logic [7:0]  txWordIdx,
  output logic             txValid,
  output logic      [15:0] txWord,
  // Status
  output logic             linkActive,
  output logic             commErr,
  output logic             syncMode,
  output logic             freezeMode
);
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [15:0] swapWord(input logic [15:0] w, input logic en);
    swapWord = en ? {w[7:0], w[15:8]} : w;
  endfunction

  function automatic logic inRange(input logic [11:0] a, input logic [11:0] lo,
                                   input logic [11:0] hi);
    inRange = (a >= lo) && (a <= hi);
  endfunction

  // ----------------
  // Declarations
  // ----------------
  typedef enum logic [2:0] {
    FBS_WAIT_PRM = 3'b001,
    FBS_WAIT_CFG = 3'b010,
    FBS_DATA     = 3'b100
  } fbs_state_t;

  fbs_state_t  state_ff;
  fbs_state_t  nxt_state;
  logic [6:0]  station_ff;
  logic        wdogEn_ff;
  logic [15:0] wdogFactor_ff;
  logic [7:0]  minTsdr_ff;
  logic [7:0]  groups_ff;
  logic        swap_ff;
  logic        layout_ff;
  logic        prmBad_ff;
  logic        prmOk;
  logic        cfgOk;
  logic        gcHit;
  logic        wdogExpired;
  logic        respDone;
  logic [7:0]  txIdx_ff;
  logic        syncMode_ff;
  logic        freezeMode_ff;
  logic        commErr_ff;
  logic        linkActive_ff;
  logic [15:0] outStage_ff [AREA_WORDS];
  logic [15:0] outArea_ff  [AREA_WORDS];
  logic [15:0] inArea_ff   [AREA_WORDS];
  logic [15:0] inFrozen_ff [AREA_WORDS];
  logic [15:0] txSrc;
  logic [11:0] outOff;
  logic [11:0] inOff;
  logic        doSync;
  logic        doFreeze;

  // ----------------
  // Parameter checks
  // ----------------
  assign prmOk = (prmStation <= ADDR_MAX)
              && (!prmWdogEn || (prmWdogFactor >= WDOG_MIN
                                 && prmWdogFactor <= WDOG_MAX))
              && (prmMinTsdr >= TSDR_MIN);

  assign cfgOk = (cfgModCount >= MOD_MIN) && (cfgModCount <= MOD_MAX)
              && (cfgMaxPattern < PAT_COUNT);

  // Any shared group bit addresses us; each bit is one group
  assign gcHit = gcValid && ((gcGroups & groups_ff) != 8'h0);
  assign doSync   = gcHit && (gcCmd == FBS_GC_SYNC);
  assign doFreeze = gcHit && (gcCmd == FBS_GC_FREEZE);

  // ----------------
  // Link state machine
  // ----------------
  // Data exchange needs parameters then configuration first
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      FBS_WAIT_PRM:
        if (prmValid && prmOk)
          nxt_state = FBS_WAIT_CFG;
      FBS_WAIT_CFG:
        if (cfgValid && cfgOk)
          nxt_state = FBS_DATA;
        else if (prmValid && !prmOk)
          nxt_state = FBS_WAIT_PRM;
      FBS_DATA:
        if (linkStop || wdogExpired)
          nxt_state = FBS_WAIT_PRM;
        else if (prmValid && !prmOk)
          nxt_state = FBS_WAIT_PRM;
        else if (prmValid)
          nxt_state = FBS_WAIT_CFG;
      default:
        nxt_state = FBS_WAIT_PRM;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      state_ff <= FBS_WAIT_PRM;
    else
      state_ff <= nxt_state;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      linkActive_ff <= 1'b0;
    else
      linkActive_ff <= (nxt_state == FBS_DATA);

  // ----------------
  // Slave parameter store
  // ----------------
  // Defaults: no swap, contiguous layout, no groups, watchdog off
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      station_ff    <= 7'h0;
      wdogEn_ff     <= 1'b0;
      wdogFactor_ff <= 16'h0;
      minTsdr_ff    <= TSDR_MIN;
      groups_ff     <= 8'h0;
      swap_ff       <= SWAP_OFF;
      layout_ff     <= CONTIGUOUS_LAYOUT;
    end
    else if (prmValid && prmOk)
    begin
      station_ff    <= prmStation;
      wdogEn_ff     <= prmWdogEn;
      wdogFactor_ff <= prmWdogFactor;
      minTsdr_ff    <= prmMinTsdr;
      groups_ff     <= prmGroups;
      swap_ff       <= (prmSwap == SWAP_ON);
      layout_ff     <= (prmLayout == SPLIT_LAYOUT);
    end

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      prmBad_ff <= 1'b0;
    else if (prmValid)
      prmBad_ff <= !prmOk;
    else if (cfgValid && state_ff == FBS_WAIT_CFG)
      prmBad_ff <= !cfgOk;

  // ----------------
  // Watchdog and error flag
  // ----------------
  fbs_wdog #(
    .TICK_CYCLES (WDOG_TICK)
  ) uWdog (
    .clk_sys (clk_sys),
    .rst     (rst),
    .enable  (wdogEn_ff && state_ff == FBS_DATA),
    .kick    (frameRx),
    .factor  (wdogFactor_ff),
    .expired (wdogExpired)
  );

  // Expiry beats a software clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      commErr_ff <= 1'b0;
    else if (wdogExpired && state_ff == FBS_DATA)
      commErr_ff <= 1'b1;
    else if (regWr && regAddr == REG_CTRL && regWrData[CT_ERRCLR])
      commErr_ff <= 1'b0;

  // ----------------
  // Global control modes
  // ----------------
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      syncMode_ff <= 1'b0;
    else if (!linkActive_ff)
      syncMode_ff <= 1'b0;
    else if (doSync)
      syncMode_ff <= 1'b1;
    else if (gcHit && gcCmd == FBS_GC_UNSYNC)
      syncMode_ff <= 1'b0;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      freezeMode_ff <= 1'b0;
    else if (!linkActive_ff)
      freezeMode_ff <= 1'b0;
    else if (doFreeze)
      freezeMode_ff <= 1'b1;
    else if (gcHit && gcCmd == FBS_GC_UNFREEZE)
      freezeMode_ff <= 1'b0;

  // ----------------
  // Output receive path
  // ----------------
  assign outOff = regAddr - OUT_BASE;
  assign inOff  = regAddr - IN_BASE;

  // Stage always tracks the master; the area is what the user sees
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < AREA_WORDS; i++)
        outStage_ff[i] <= 16'h0;
    end
    else if (rxWordValid && linkActive_ff && int'(rxWordIdx) < AREA_WORDS)
      outStage_ff[rxWordIdx] <= swapWord(rxWord, swap_ff);

  // Whole-area copy on SYNC keeps every word of one cycle together
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < AREA_WORDS; i++)
        outArea_ff[i] <= 16'h0;
    end
    else if (doSync && linkActive_ff)
    begin
      for (int i = 0; i < AREA_WORDS; i++)
        outArea_ff[i] <= outStage_ff[i];
    end
    else if (!syncMode_ff && rxWordValid && linkActive_ff
             && int'(rxWordIdx) < AREA_WORDS)
      outArea_ff[rxWordIdx] <= swapWord(rxWord, swap_ff);

  // ----------------
  // Input send path
  // ----------------
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < AREA_WORDS; i++)
        inArea_ff[i] <= 16'h0;
    end
    else if (regWr && inRange(regAddr, IN_BASE, IN_LAST))
      inArea_ff[inOff[7:0]] <= regWrData;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      for (int i = 0; i < AREA_WORDS; i++)
        inFrozen_ff[i] <= 16'h0;
    end
    else if (doFreeze && linkActive_ff)
    begin
      for (int i = 0; i < AREA_WORDS; i++)
        inFrozen_ff[i] <= inArea_ff[i];
    end

  // Index is latched at the request; the word is read from the area when the delay ends
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      txIdx_ff <= 8'h0;
    else if (txReq)
      txIdx_ff <= txWordIdx;

  always_comb
  begin
    txSrc = 16'h0;
    if (int'(txIdx_ff) < AREA_WORDS)
      txSrc = freezeMode_ff ? inFrozen_ff[txIdx_ff]
                            : inArea_ff[txIdx_ff];
  end

  fbs_resp_delay #(
    .BIT_CYCLES (BIT_CYC)
  ) uResp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .start   (txReq && linkActive_ff),
    .bits    (minTsdr_ff),
    .done    (respDone)
  );

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      txValid <= 1'b0;
      txWord  <= 16'h0;
    end
    else
    begin
      txValid <= respDone && linkActive_ff;
      if (respDone)
        txWord <= swapWord(txSrc, swap_ff);
    end

  // ----------------
  // Register read port
  // ----------------
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      regRdData <= 16'h0;
    else if (regRd)
    begin
      regRdData <= 16'h0;
      if (inRange(regAddr, OUT_BASE, OUT_LAST))
        regRdData <= outArea_ff[outOff[7:0]];
      else if (inRange(regAddr, IN_BASE, IN_LAST))
        regRdData <= inArea_ff[inOff[7:0]];
      else if (regAddr == REG_STATUS)
      begin
        regRdData[ST_LINK]   <= linkActive_ff;
        regRdData[ST_ERR]    <= commErr_ff;
        regRdData[ST_SYNC]   <= syncMode_ff;
        regRdData[ST_FREEZE] <= freezeMode_ff;
        regRdData[ST_SWAP]   <= swap_ff;
        regRdData[ST_LAYOUT] <= layout_ff;
        regRdData[ST_PRMBAD] <= prmBad_ff;
      end
      else if (regAddr == REG_PRM0)
        regRdData <= {groups_ff, 1'b0, station_ff};
      else if (regAddr == REG_PRM1)
        regRdData <= wdogEn_ff ? wdogFactor_ff : 16'h0;
    end
    else
      regRdData <= 16'h0;

  // ----------------
  // Status outputs
  // ----------------
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
    begin
      linkActive <= 1'b0;
      commErr    <= 1'b0;
      syncMode   <= 1'b0;
      freezeMode <= 1'b0;
    end
    else
    begin
      linkActive <= linkActive_ff;
      commErr    <= commErr_ff;
      syncMode   <= syncMode_ff;
      freezeMode <= freezeMode_ff;
    end
endmodule
`default_nettype wire

// ==== fbs_slave_asserts.sv ====
// Purpose: Port-level timing checks for fbs_slave
// Assumes: Groups and delay come from the last parameter frame
// Notes:   Bound into every fbs_slave instance
`default_nettype none
module fbs_slave_chk
  import fbs_pkg::*;
#(
  parameter int BIT_CYC = TSDR_BIT_CYC
)(
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       rst,
  // Master side
  input wire logic       prmValid,
  input wire logic [7:0] prmMinTsdr,
  input wire logic [7:0] prmGroups,
  input wire logic       cfgValid,
  input wire logic       linkStop,
  input wire logic       gcValid,
  input wire fbs_gc_t    gcCmd,
  input wire logic [7:0] gcGroups,
  input wire logic       txReq,
  // Results
  input wire logic       txValid,
  input wire logic       linkActive,
  input wire logic       commErr,
  input wire logic       syncMode,
  input wire logic       freezeMode
);
  logic [7:0]  grp_ff;
  logic [7:0]  tsdr_ff;
  logic [11:0] txCnt_ff;
  logic        hit;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  assign hit = gcValid && linkActive && ((gcGroups & grp_ff) != 8'h00);
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      grp_ff   <= 8'h00;
      tsdr_ff  <= 8'h01;
      txCnt_ff <= 12'hfff;
    end
    else
    begin
      if (prmValid)
      begin
        grp_ff  <= prmGroups;
        tsdr_ff <= prmMinTsdr;
      end
      txCnt_ff <= txReq ? 12'h001 : txCnt_ff + 12'(txCnt_ff != 12'hfff);
    end
  end
  chk_link_rise: assert property ($rose(linkActive) |-> $past(cfgValid, 2))
    else $error("link flag rose without config frame");
  chk_link_stop: assert property (linkStop |-> ##3 !linkActive)
    else $error("link flag kept after stop");
  chk_sync_on: assert property (hit && gcCmd == FBS_GC_SYNC |-> ##2 syncMode)
    else $error("sync not entered");
  chk_sync_off: assert property (hit && gcCmd == FBS_GC_UNSYNC |-> ##2 !syncMode)
    else $error("sync not left");
  chk_freeze_on: assert property (hit && gcCmd == FBS_GC_FREEZE |-> ##2 freezeMode)
    else $error("freeze not entered");
  chk_freeze_off: assert property (hit && gcCmd == FBS_GC_UNFREEZE |=> ##1 !freezeMode)
    else $error("freeze not left");
  chk_group_miss: assert property (gcValid && (gcGroups & grp_ff) == 8'h00
    |=> ##1 $stable({syncMode, freezeMode}))
    else $error("foreign group command acted on");
  chk_tx_exact: assert property (txValid |-> txCnt_ff == tsdr_ff * BIT_CYC + 2)
    else $error("response delay wrong");
  chk_tx_early: assert property (txReq |=> !txValid [*2])
    else $error("response too early");
  chk_err_link: assert property ($rose(commErr) |-> $past(linkActive))
    else $error("comm error outside data exchange");
  chk_mode_link: assert property (syncMode || freezeMode
    |-> linkActive || $past(linkActive))
    else $error("mode set without link");
  cover property (hit && gcCmd == FBS_GC_FREEZE);
  cover property ($rose(syncMode));
  cover property (txValid);
  cover property ($rose(commErr));
endmodule
bind fbs_slave fbs_slave_chk #(.BIT_CYC(BIT_CYC)) chk_u (.*);
`default_nettype wire

// ==== fbs_wdog.sv ====
// Purpose: Communication watchdog in units of a prescaled tick
// Assumes: factor is held stable while enabled
// Notes:   Expired is a level, cleared by the next kick
`default_nettype none
module fbs_wdog
  import fbs_pkg::*;
#(
  parameter int TICK_CYCLES = WDOG_TICK_CYC
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Control
  input  wire logic        enable,
  input  wire logic        kick,
  input  wire logic [15:0] factor,
  // Result
  output logic             expired
);
  logic [31:0] preCnt_ff;
  logic [15:0] tickCnt_ff;
  logic        tick;

  assign tick = (preCnt_ff == 32'(TICK_CYCLES - 1));

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      preCnt_ff <= 32'h0;
    else if (kick || !enable || tick)
      preCnt_ff <= 32'h0;
    else
      preCnt_ff <= preCnt_ff + 32'h1;

  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      tickCnt_ff <= 16'h0;
    else if (kick || !enable)
      tickCnt_ff <= 16'h0;
    else if (tick && tickCnt_ff != factor)
      tickCnt_ff <= tickCnt_ff + 16'h1;

  // Disabled watchdog can never expire
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      expired <= 1'b0;
    else if (kick || !enable)
      expired <= 1'b0;
    else if (tickCnt_ff == factor)
      expired <= 1'b1;
endmodule
`default_nettype wire

// ==== tb_fbs_slave.sv ====
// Purpose: Self-checking bench for fbs_slave
// Assumes: Watchdog tick cut to 4 cycles
// Notes:   Master side comes from fbs_master_model
`default_nettype none
module tb_fbs_slave
  import fbs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst, regWr, regRd, prmValid, prmWdogEn, prmSwap, prmLayout;
  logic        cfgValid, frameRx, linkStop, gcValid, rxWordValid, txReq, txValid;
  logic        linkActive, commErr, syncMode, freezeMode;
  logic [5:0]  cfgModCount;
  logic [6:0]  prmStation, cfgMaxPattern;
  logic [7:0]  prmMinTsdr, prmGroups, gcGroups, rxWordIdx, txWordIdx, grp, ix;
  logic [11:0] regAddr;
  logic [15:0] regWrData, regRdData, prmWdogFactor, rxWord, txWord, w, a, b;
  fbs_gc_t     gcCmd;
  logic [31:0] seed;
  int          errors, n_compared, cyc;
  fbs_slave #(.WDOG_TICK(4)) dut_u (.*);
  fbs_master_model m (.*);
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] swp(input logic [15:0] x);
    return {x[7:0], x[15:8]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [11:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    {regWr, regAddr, regWrData} <= {1'b1, ad, d};
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] ad, output logic [15:0] d);
    @(posedge clk_sys);
    {regRd, regAddr} <= {1'b1, ad};
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic up(input logic [1:0] sl, input logic [7:0] t, input logic en);
    m.send_prm(7'h7d, en, 16'h0002, t, grp, sl);
    m.send_cfg(6'h28, 7'h5f);
    step(2);
    chk(linkActive, 1'b1);
  endtask
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------
  // Clock and cap
  // ----------------
  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errors++;
      summarize();
    end
  end
  // ----------------
  // Scenarios
  // ----------------
  initial
  begin
    seed = 32'h10;
    {rst, regWr, regRd, regAddr, regWrData} = {1'b1, 30'h0};
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    step(1);
    chk({linkActive, commErr, syncMode, freezeMode, txValid}, 16'h0000);
    rd(REG_STATUS, w);
    chk(w, 16'h0000);
    rd(12'h3ff, w);
    chk(w, 16'h0000);
    $display("reset test done");
    grp = (8'(xs()) | 8'h01) & 8'h7f;
    m.gap = xs() % 3;
    up(2'b11, 8'(xs() % 8) + 8'h01, 1'b0);
    rd(REG_STATUS, w);
    chk(w[5:4], 2'b11);
    for (int i = 0; i < 6; i++)
    begin
      ix = (i == 0) ? 8'hbf : 8'(xs() % AREA_WORDS);
      a = 16'(xs());
      m.send_rx(ix, a);
      rd(OUT_BASE + 12'(ix), w);
      chk(w, swp(a));
      wr(IN_BASE + 12'(ix), a);
      m.fetch(ix, w);
      chk(w, swp(a));
    end
    $display("swap test done");
    m.gap = 0;
    for (int i = 0; i < NUM_GROUPS; i++)
    begin
      m.send_gc(FBS_GC_SYNC, 8'h01 << i);
      step(2);
      chk(syncMode, grp[i]);
      m.send_gc(FBS_GC_UNSYNC, 8'hff);
      step(2);
      chk(syncMode, 1'b0);
    end
    b = ~a;
    m.send_rx(8'h00, a);
    m.send_gc(FBS_GC_SYNC, grp);
    m.send_rx(8'h00, b);
    rd(OUT_BASE, w);
    chk(w, swp(a));
    m.send_gc(FBS_GC_SYNC, grp);
    rd(OUT_BASE, w);
    chk(w, swp(b));
    m.send_gc(FBS_GC_UNSYNC, grp);
    m.send_rx(8'h00, a);
    rd(OUT_BASE, w);
    chk(w, swp(a));
    wr(IN_BASE, a);
    m.send_gc(FBS_GC_FREEZE, grp);
    wr(IN_BASE, b);
    m.fetch(8'h00, w);
    chk(w, swp(a));
    chk(freezeMode, 1'b1);
    m.send_gc(FBS_GC_FREEZE, grp);
    m.fetch(8'h00, w);
    chk(w, swp(b));
    m.send_gc(FBS_GC_UNFREEZE, grp);
    wr(IN_BASE, a);
    m.fetch(8'h00, w);
    chk(w, swp(a));
    chk(freezeMode, 1'b0);
    $display("group test done");
    up(2'b00, 8'h01, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      a = 16'(xs());
      m.send_rx(8'(i), a);
      rd(OUT_BASE + 12'(i), w);
      chk(w, a);
    end
    chk(commErr, 1'b0);
    step(12);
    chk({commErr, linkActive}, 2'b10);
    wr(REG_CTRL, 16'h0001);
    rd(REG_STATUS, w);
    chk(w[ST_ERR], 1'b0);
    up(2'b00, 8'hff, 1'b0);
    step(40);
    chk(commErr, 1'b0);
    wr(IN_BASE, b);
    m.fetch(8'h00, w);
    chk(w, b);
    $display("watchdog test done");
    m.send_prm(7'h7e, 1'b0, 16'h0000, 8'h01, grp, 2'b00);
    rd(REG_STATUS, w);
    chk(w[ST_PRMBAD], 1'b1);
    m.send_cfg(6'h01, 7'h00);
    step(3);
    chk(linkActive, 1'b0);
    m.send_prm(7'h00, 1'b0, 16'h0000, 8'h01, grp, 2'b00);
    m.send_cfg(6'h29, 7'h00);
    step(3);
    chk(linkActive, 1'b0);
    m.send_cfg(6'h01, 7'h60);
    step(3);
    chk(linkActive, 1'b0);
    m.send_cfg(6'h01, 7'h00);
    step(2);
    chk(linkActive, 1'b1);
    m.drop_link();
    step(2);
    chk(linkActive, 1'b0);
    $display("refusal test done");
    summarize();
  end
endmodule
`default_nettype wire
